// >>> lfbl_pkg.sv
// Constants shared by the legacy link byte device end and its host end
// Functional notes
// - Shift link bits into byte, flag full
// - Full flag drives interrupt when enabled
// - Host reads byte within one byte time
// - Byte equal to match byte sets flag
// - Destuffer drops zero after five ones
// - Zero after six ones is kept
// - Host enables destuffer when extracting link
// - First received bit lands in bit 0
// - Transmit byte sent LSB first
// - Eight bits sent sets empty flag
// - Unreloaded transmit byte is sent again
// - Stuffer inserts zero after five ones
// - Host loads first framer byte with 1Ch
// - D4 needs Fs from byte, multiframe load
// - Only one transmit source drives link
package lfbl_pkg;
  // Number of framers served by the device end
  localparam int NUM_FRAMERS = 2;
  // Link byte register offsets, framer B then framer A as written (index 0 is framer A)
  localparam logic [1:0][7:0] RX_BYTE_OFS = {8'hC8, 8'h28};
  localparam logic [1:0][7:0] MATCH1_OFS = {8'hC9, 8'h29};
  localparam logic [1:0][7:0] MATCH2_OFS = {8'hCA, 8'h2A};
  localparam logic [1:0][7:0] TX_BYTE_OFS = {8'hFE, 8'h7E};
  // Status, mask and control registers per framer
  localparam logic [1:0][7:0] STAT_OFS = {8'hC0, 8'h20};
  localparam logic [1:0][7:0] MASK_OFS = {8'hC1, 8'h21};
  localparam logic [1:0][7:0] CTRL_OFS = {8'hC2, 8'h22};
  // Status and mask field positions
  localparam int RX_MATCH_BIT = 2;
  localparam int TX_EMPTY_BIT = 3;
  localparam int RX_FULL_BIT = 4;
  // Control field positions
  localparam int RX_DESTUFF_BIT = 0;
  localparam int FS_SOURCE_BIT = 2;
  localparam int TX_STUFF_BIT = 4;
  localparam int MF_LOAD_BIT = 5;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TX_BYTE_RESET = 8'h00;
  // Byte width and run length of ones that triggers stuffing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] RUN_SAT = 3'h6;
  // Host command port register offsets
  localparam logic [3:0] H_ADDR_OFS = 4'h0;
  localparam logic [3:0] H_WDATA_OFS = 4'h1;
  localparam logic [3:0] H_CMD_OFS = 4'h2;
  localparam logic [3:0] H_RDATA_OFS = 4'h3;
  localparam logic [3:0] H_STAT_OFS = 4'h4;
  localparam logic [3:0] H_MASK_OFS = 4'h5;
  // Host command and status bits
  localparam int H_CMD_WR_BIT = 0;
  localparam int H_CMD_RD_BIT = 1;
  localparam int H_RD_DONE_BIT = 0;
  localparam int H_DEV_INT_BIT = 1;
  // Host bus sequencer states
  typedef enum logic [1:0] {
    LFBL_IDLE = 2'b00,
    LFBL_ISSUE = 2'b01,
    LFBL_CAPTURE = 2'b11
  } lfbl_hstate_e;
endpackage

// >>> lfbl_if.sv
// Parallel register bus joining the host end and the device end
interface lfbl_if;
  logic [7:0] addr; // Register address
  logic [7:0] wdata; // Write data
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [7:0] rdata; // Read data, valid the cycle after rd
  logic int_n; // Active-low interrupt level

  // Device end answers the bus
  modport device (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output int_n
  );

  // Host end drives the bus
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input int_n
  );
endinterface

// >>> lfbl_rx_chan.sv
// Receive link byte path for one framer: destuffer, shifter and matcher
module lfbl_rx_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Recovered link bit stream
  input wire logic rx_en,
  input wire logic rx_bit,
  // Configuration
  input wire logic rx_destuff_en,
  input wire logic [7:0] rx_match_byte1,
  input wire logic [7:0] rx_match_byte2,
  // Results
  output logic [7:0] rx_link_byte,
  output logic rx_full_p,
  output logic rx_match_p
);
  logic [7:0] shift; // Bits collected so far
  logic [2:0] bit_cnt; // Bits collected in this byte
  logic [2:0] ones; // Run of ones, saturating at six
  logic drop; // Current bit is a stuffed zero
  logic [7:0] next_byte; // Shifter with current bit taken in

  // A zero right after exactly five ones is stuffing; after six it is a flag
  assign drop = rx_destuff_en && !rx_bit && (ones == lfbl_pkg::STUFF_RUN);
  // New bit enters at the top so the first bit ends in bit 0
  assign next_byte = {rx_bit, shift[7:1]};

  // Run length of ones seen on the raw line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones <= 3'h0;
    end else if (rx_en) begin
      if (!rx_bit) begin
        ones <= 3'h0;
      end else if (ones != lfbl_pkg::RUN_SAT) begin
        ones <= ones + 3'h1;
      end
    end
  end

  // Shifter and byte completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= lfbl_pkg::REG_RESET;
      bit_cnt <= 3'h0;
      rx_link_byte <= lfbl_pkg::REG_RESET;
      rx_full_p <= 1'b0;
      rx_match_p <= 1'b0;
    end else begin
      rx_full_p <= 1'b0;
      rx_match_p <= 1'b0;
      if (rx_en && !drop) begin
        shift <= next_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == lfbl_pkg::LAST_BIT) begin
          // Unread byte is overwritten; host must keep pace
          rx_link_byte <= next_byte;
          rx_full_p <= 1'b1;
          rx_match_p <= (next_byte == rx_match_byte1) ||
                        (next_byte == rx_match_byte2);
        end
      end
    end
  end
endmodule

// >>> lfbl_device.sv
// Device end: legacy link byte registers, transmit serializers, interrupt
module lfbl_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  lfbl_if.device bus,
  // Framer receive stream, one bit slot pulse per link bit
  input wire logic [1:0] rx_en,
  input wire logic [1:0] rx_bit,
  // Framer transmit stream
  input wire logic [1:0] tx_en,
  input wire logic [1:0] mf_start,
  input wire logic [1:0] d4_mode,
  input wire logic [1:0] msg_ctrl_tx,
  output logic [1:0] tx_bit,
  output logic [1:0] tx_drive
);
  // Per-framer register storage
  logic [7:0] rx_match_byte1 [2]; // First match byte
  logic [7:0] rx_match_byte2 [2]; // Second match byte
  logic [7:0] tx_link_byte [2]; // Byte queued for transmit
  logic [7:0] stat [2]; // Sticky status flags
  logic [7:0] mask [2]; // Interrupt enables
  logic [7:0] ctrl [2]; // Control bits
  logic [7:0] rx_link_byte [2]; // Last completed receive byte
  // Per-framer events
  logic [1:0] rx_full_p; // Receive byte completed
  logic [1:0] rx_match_p; // Completed byte matched
  logic [1:0] tx_empty_p; // Transmit byte fully sent
  // Transmit serializer state
  logic [7:0] tx_shift [2]; // Bits still to send
  logic [7:0] tx_held [2]; // Byte taken at the last load
  logic [2:0] tx_cnt [2]; // Bits sent of current byte
  logic [2:0] tx_ones [2]; // Run of ones sent
  // Read path
  logic [7:0] next_rdata; // Read mux result
  logic [1:0] irq_any; // Unmasked flag per framer

  genvar g;
  generate
    for (g = 0; g < lfbl_pkg::NUM_FRAMERS; g++) begin : gen_fr
      logic wr_match1; // Write to first match byte
      logic wr_match2; // Write to second match byte
      logic wr_tx; // Write to transmit byte
      logic wr_stat; // Write-one-to-clear of status
      logic wr_mask; // Write to mask
      logic wr_ctrl; // Write to control
      logic src_here; // This path owns the transmit slot
      logic stuff_now; // Insert a zero in this slot
      logic [7:0] events; // Events in status layout

      assign wr_match1 = bus.wr && (bus.addr == lfbl_pkg::MATCH1_OFS[g]);
      assign wr_match2 = bus.wr && (bus.addr == lfbl_pkg::MATCH2_OFS[g]);
      assign wr_tx = bus.wr && (bus.addr == lfbl_pkg::TX_BYTE_OFS[g]);
      assign wr_stat = bus.wr && (bus.addr == lfbl_pkg::STAT_OFS[g]);
      assign wr_mask = bus.wr && (bus.addr == lfbl_pkg::MASK_OFS[g]);
      assign wr_ctrl = bus.wr && (bus.addr == lfbl_pkg::CTRL_OFS[g]);

      // The message controller, or an external Fs source in D4 mode, takes the slot away
      assign src_here = !msg_ctrl_tx[g] &&
                        !(d4_mode[g] && ctrl[g][lfbl_pkg::FS_SOURCE_BIT]);
      // Zero goes out after five ones when stuffing is on
      assign stuff_now = ctrl[g][lfbl_pkg::TX_STUFF_BIT] &&
                         (tx_ones[g] == lfbl_pkg::STUFF_RUN);

      always_comb begin
        events = 8'h00;
        events[lfbl_pkg::RX_MATCH_BIT] = rx_match_p[g];
        events[lfbl_pkg::TX_EMPTY_BIT] = tx_empty_p[g];
        events[lfbl_pkg::RX_FULL_BIT] = rx_full_p[g];
      end

      // Receive path for this framer
      lfbl_rx_chan u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .rx_en(rx_en[g]),
        .rx_bit(rx_bit[g]),
        .rx_destuff_en(ctrl[g][lfbl_pkg::RX_DESTUFF_BIT]),
        .rx_match_byte1(rx_match_byte1[g]),
        .rx_match_byte2(rx_match_byte2[g]),
        .rx_link_byte(rx_link_byte[g]),
        .rx_full_p(rx_full_p[g]),
        .rx_match_p(rx_match_p[g])
      );

      // Software-written configuration registers
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_match_byte1[g] <= lfbl_pkg::REG_RESET;
          rx_match_byte2[g] <= lfbl_pkg::REG_RESET;
          tx_link_byte[g] <= lfbl_pkg::TX_BYTE_RESET;
          mask[g] <= lfbl_pkg::REG_RESET;
          ctrl[g] <= lfbl_pkg::REG_RESET;
        end else begin
          if (wr_match1) begin
            rx_match_byte1[g] <= bus.wdata;
          end
          if (wr_match2) begin
            rx_match_byte2[g] <= bus.wdata;
          end
          if (wr_tx) begin
            tx_link_byte[g] <= bus.wdata;
          end
          if (wr_mask) begin
            mask[g] <= bus.wdata;
          end
          if (wr_ctrl) begin
            ctrl[g] <= bus.wdata;
          end
        end
      end

      // Sticky status; an event in the clearing cycle still sets its flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat[g] <= lfbl_pkg::REG_RESET;
        end else begin
          stat[g] <= (stat[g] & ~(wr_stat ? bus.wdata : 8'h00)) | events;
        end
      end

      // Serializer: LSB first, stuffing, reload at byte or multiframe edge
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_shift[g] <= lfbl_pkg::TX_BYTE_RESET;
          tx_held[g] <= lfbl_pkg::TX_BYTE_RESET;
          tx_cnt[g] <= 3'h0;
          tx_ones[g] <= 3'h0;
          tx_bit[g] <= 1'b0;
          tx_empty_p[g] <= 1'b0;
        end else begin
          tx_empty_p[g] <= 1'b0;
          if (ctrl[g][lfbl_pkg::MF_LOAD_BIT] && mf_start[g]) begin
            // Multiframe load restarts the byte on the boundary
            tx_shift[g] <= tx_link_byte[g];
            tx_held[g] <= tx_link_byte[g];
            tx_cnt[g] <= 3'h0;
          end else if (tx_en[g] && src_here) begin
            if (stuff_now) begin
              // Inserted zero does not consume a data bit
              tx_bit[g] <= 1'b0;
              tx_ones[g] <= 3'h0;
            end else begin
              tx_bit[g] <= tx_shift[g][0];
              tx_ones[g] <= tx_shift[g][0] ? tx_ones[g] + 3'h1 : 3'h0;
              tx_shift[g] <= {1'b0, tx_shift[g][7:1]};
              tx_cnt[g] <= tx_cnt[g] + 3'h1;
              if (tx_cnt[g] == lfbl_pkg::LAST_BIT) begin
                tx_empty_p[g] <= 1'b1;
                // Without a fresh write the same byte goes out again
                if (ctrl[g][lfbl_pkg::MF_LOAD_BIT]) begin
                  tx_shift[g] <= tx_held[g];
                end else begin
                  tx_shift[g] <= tx_link_byte[g];
                  tx_held[g] <= tx_link_byte[g];
                end
              end
            end
          end
        end
      end

      // Marks the slots this path really drives
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_drive[g] <= 1'b0;
        end else begin
          tx_drive[g] <= src_here;
        end
      end

      assign irq_any[g] = |(stat[g] & mask[g]);
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < lfbl_pkg::NUM_FRAMERS; i++) begin
      if (bus.addr == lfbl_pkg::RX_BYTE_OFS[i]) begin
        next_rdata = rx_link_byte[i];
      end else if (bus.addr == lfbl_pkg::MATCH1_OFS[i]) begin
        next_rdata = rx_match_byte1[i];
      end else if (bus.addr == lfbl_pkg::MATCH2_OFS[i]) begin
        next_rdata = rx_match_byte2[i];
      end else if (bus.addr == lfbl_pkg::TX_BYTE_OFS[i]) begin
        next_rdata = tx_link_byte[i];
      end else if (bus.addr == lfbl_pkg::STAT_OFS[i]) begin
        next_rdata = stat[i];
      end else if (bus.addr == lfbl_pkg::MASK_OFS[i]) begin
        next_rdata = mask[i];
      end else if (bus.addr == lfbl_pkg::CTRL_OFS[i]) begin
        next_rdata = ctrl[i];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= 8'h00;
    end else begin
      bus.rdata <= bus.rd ? next_rdata : 8'h00;
    end
  end

  // Interrupt low while any enabled flag stands, one cycle behind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.int_n <= 1'b1;
    end else begin
      bus.int_n <= !(|irq_any);
    end
  end
endmodule

// >>> lfbl_host.sv
// Host end: turns software commands into device bus cycles
module lfbl_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software command port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq,
  // Device bus
  lfbl_if.host bus
);
  logic [7:0] tgt_addr; // Device address for the next cycle
  logic [7:0] tgt_wdata; // Device write data
  logic [7:0] rd_result; // Last device read data
  logic [7:0] h_stat; // Sticky host events
  logic [7:0] h_mask; // Host interrupt enables
  logic is_write; // Pending cycle is a write
  logic rd_done_p; // Device read completed
  lfbl_pkg::lfbl_hstate_e state; // Bus sequencer
  logic cmd_go; // Command register written with a request
  logic [7:0] events; // Events in status layout

  assign cmd_go = sw_wr && (sw_addr == lfbl_pkg::H_CMD_OFS) &&
                  (sw_wdata[lfbl_pkg::H_CMD_WR_BIT] || sw_wdata[lfbl_pkg::H_CMD_RD_BIT]);

  always_comb begin
    events = 8'h00;
    events[lfbl_pkg::H_RD_DONE_BIT] = rd_done_p;
    events[lfbl_pkg::H_DEV_INT_BIT] = !bus.int_n;
  end

  // Software registers; commands arriving while busy are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_addr <= 8'h00;
      tgt_wdata <= 8'h00;
      h_mask <= 8'h00;
      is_write <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == lfbl_pkg::H_ADDR_OFS) begin
        tgt_addr <= sw_wdata;
      end
      if (sw_wr && sw_addr == lfbl_pkg::H_WDATA_OFS) begin
        tgt_wdata <= sw_wdata;
      end
      if (sw_wr && sw_addr == lfbl_pkg::H_MASK_OFS) begin
        h_mask <= sw_wdata;
      end
      if (cmd_go && state == lfbl_pkg::LFBL_IDLE) begin
        is_write <= sw_wdata[lfbl_pkg::H_CMD_WR_BIT];
      end
    end
  end

  // Sequencer: one strobe, then capture read data a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= lfbl_pkg::LFBL_IDLE;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rd_result <= 8'h00;
      rd_done_p <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      rd_done_p <= 1'b0;
      case (state)
        lfbl_pkg::LFBL_IDLE: begin
          if (cmd_go) begin
            state <= lfbl_pkg::LFBL_ISSUE;
          end
        end
        lfbl_pkg::LFBL_ISSUE: begin
          bus.addr <= tgt_addr;
          bus.wdata <= tgt_wdata;
          bus.wr <= is_write;
          bus.rd <= !is_write;
          state <= is_write ? lfbl_pkg::LFBL_IDLE : lfbl_pkg::LFBL_CAPTURE;
        end
        lfbl_pkg::LFBL_CAPTURE: begin
          // Strobe is out this cycle; data arrives on the next edge
          if (!bus.rd) begin
            rd_result <= bus.rdata;
            rd_done_p <= 1'b1;
            state <= lfbl_pkg::LFBL_IDLE;
          end
        end
        default: begin
          state <= lfbl_pkg::LFBL_IDLE;
        end
      endcase
    end
  end

  // Sticky host status, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_stat <= 8'h00;
    end else begin
      h_stat <= (h_stat & ~((sw_wr && sw_addr == lfbl_pkg::H_STAT_OFS) ? sw_wdata : 8'h00))
                | events;
    end
  end

  // Software read data one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq <= |(h_stat & h_mask);
      sw_rdata <= 8'h00;
      if (sw_rd) begin
        case (sw_addr)
          lfbl_pkg::H_ADDR_OFS: sw_rdata <= tgt_addr;
          lfbl_pkg::H_WDATA_OFS: sw_rdata <= tgt_wdata;
          lfbl_pkg::H_RDATA_OFS: sw_rdata <= rd_result;
          lfbl_pkg::H_STAT_OFS: sw_rdata <= h_stat;
          lfbl_pkg::H_MASK_OFS: sw_rdata <= h_mask;
          lfbl_pkg::H_CMD_OFS: sw_rdata <= {7'h00, state != lfbl_pkg::LFBL_IDLE};
          default: sw_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> lfbl_assertions.sv
// Checker watching the register bus between the host end and the device end
module lfbl_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic int_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Copy of every plain read-write byte, so a later read can be judged
  logic [7:0] shadow [256];
  // Mask bits of framer A that can matter (the device stores all eight, only three have events)
  logic [7:0] mask_a;

  // Full read-write bytes: match bytes and transmit bytes of both framers
  function automatic logic is_rw(input logic [7:0] a);
    return a inside {8'h29, 8'h2A, 8'h7E, 8'hC9, 8'hCA, 8'hFE};
  endfunction

  // Every decoded address; anything else is a hole
  function automatic logic is_mapped(input logic [7:0] a);
    return is_rw(a) || (a inside {8'h28, 8'hC8, 8'h20, 8'h21, 8'h22, 8'hC0, 8'hC1, 8'hC2});
  endfunction

  // Shadow follows host writes; reset value is the common register reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        shadow[i] <= 8'h00;
      end
    end else if (wr && is_rw(addr)) begin
      shadow[addr] <= wdata;
    end
  end

  // Mask shadow keeps only the implemented event bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_a <= 8'h00;
    end else if (wr && addr == 8'h21) begin
      mask_a <= wdata & 8'h1C;
    end
  end

  // A status read of framer A, then its answer with an enabled event in it
  sequence stat_read_s;
    rd && addr == 8'h20;
  endsequence
  sequence masked_hit_s;
    (rdata & mask_a) != 8'h00;
  endsequence

  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes high together");
  wr_pulse_a: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (rd |=> !rd && !wr)
    else $error("read strobe not a lone pulse");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  hole_zero_a: assert property (rd && !is_mapped(addr) |=> rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  rw_readback_a: assert property (rd && is_rw(addr) |=> rdata == shadow[$past(addr)])
    else $error("read-write byte differs from last write");
  int_cause_a: assert property (stat_read_s ##1 masked_hit_s |-> !int_n)
    else $error("interrupt high while an enabled event is reported");
  int_release_a: assert property ($rose(int_n) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt released without a host write");
endmodule

// >>> lfbl_bench.sv
// Self-checking bench joining the host end and the device end
module lfbl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and software port
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq;
  // Framer streams; framer B transmit slots are never offered
  logic [1:0] rx_en = 2'h0;
  logic [1:0] rx_bit = 2'h0;
  logic [1:0] tx_en = 2'h0;
  logic [1:0] mf_start = 2'h0;
  logic [1:0] d4_mode = 2'h0;
  logic [1:0] msg_ctrl_tx = 2'h0;
  logic [1:0] tx_bit;
  logic [1:0] tx_drive;
  // Bookkeeping
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [16:0] got;

  lfbl_if bus_if ();
  lfbl_host u_lfbl_host (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .bus(bus_if.host));
  // Multiframe boundaries come from the bench so the D4 load path is reached
  lfbl_device u_lfbl_device (.clk(clk), .rst_n(rst_n), .bus(bus_if.device), .rx_en(rx_en),
    .rx_bit(rx_bit), .tx_en(tx_en), .mf_start(mf_start), .d4_mode(d4_mode),
    .msg_ctrl_tx(msg_ctrl_tx), .tx_bit(tx_bit), .tx_drive(tx_drive));
  lfbl_assertions u_lfbl_assertions (.clk(clk), .rst_n(rst_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .int_n(bus_if.int_n));

  // 25 ns period
  always #12.5 clk = ~clk;

  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Closing report
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Byte results
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Serial results, first slot in bit 0
  task automatic check_bits(input logic [16:0] g, input logic [16:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Software port cycles: one-cycle strobes, read data the cycle after
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // Poll busy; a command sent while busy would be dropped silently
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 20; i++) begin
      sw_read(lfbl_pkg::H_CMD_OFS, s);
      if (s[0] === 1'b0) return;
    end
    check_byte(s, 8'h00);
  endtask

  // Device register access through the host end
  task automatic dev_write(input logic [7:0] a, input logic [7:0] d);
    sw_write(lfbl_pkg::H_ADDR_OFS, a);
    sw_write(lfbl_pkg::H_WDATA_OFS, d);
    sw_write(lfbl_pkg::H_CMD_OFS, 8'h01);
    wait_idle();
  endtask
  task automatic dev_read(input logic [7:0] a, output logic [7:0] d);
    sw_write(lfbl_pkg::H_ADDR_OFS, a);
    sw_write(lfbl_pkg::H_CMD_OFS, 8'h02);
    wait_idle();
    sw_read(lfbl_pkg::H_RDATA_OFS, d);
  endtask

  // Offer n received link bits to framer f, b[0] first
  task automatic rx_send(input int f, input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_en[f] <= 1'b1;
      rx_bit[f] <= b[i];
      @(posedge clk);
      rx_en[f] <= 1'b0;
    end
  endtask

  // One multiframe boundary pulse on framer A
  task automatic mf_pulse();
    @(posedge clk);
    mf_start[0] <= 1'b1;
    @(posedge clk);
    mf_start[0] <= 1'b0;
  endtask

  // Offer n transmit slots to framer A and collect what it sends
  task automatic tx_take(input int n, output logic [16:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_en[0] <= 1'b1;
      @(posedge clk);
      tx_en[0] <= 1'b0;
      #1 v[i] = tx_bit[0];
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset value, read-only byte, unmapped hole
    dev_read(8'h7E, rv);
    check_byte(rv, lfbl_pkg::TX_BYTE_RESET);
    dev_write(8'h28, 8'hFF);
    dev_read(8'h28, rv);
    check_byte(rv, lfbl_pkg::REG_RESET);
    dev_read(8'h10, rv);
    check_byte(rv, 8'h00);
    $display("Test registers done");
    // Receive on both framers; host forwards the device interrupt only
    sw_write(lfbl_pkg::H_MASK_OFS, 8'h02);
    for (int f = 0; f < 2; f++) begin
      dev_write(lfbl_pkg::MATCH1_OFS[f], 8'h3C);
      dev_write(lfbl_pkg::MATCH2_OFS[f], 8'h5A);
      dev_write(lfbl_pkg::MASK_OFS[f], 8'h14);
      // Unread byte is overwritten by the next one
      rx_send(f, 16'h0033, 8);
      rx_send(f, 16'h005A, 8);
      dev_read(lfbl_pkg::RX_BYTE_OFS[f], rv);
      check_byte(rv, 8'h5A);
      dev_read(lfbl_pkg::STAT_OFS[f], rv);
      check_byte(rv, 8'h14);
      check_byte({7'h00, irq}, 8'h01);
      dev_write(lfbl_pkg::STAT_OFS[f], 8'h14);
      sw_write(lfbl_pkg::H_STAT_OFS, 8'h03);
      dev_read(lfbl_pkg::STAT_OFS[f], rv);
      check_byte(rv, 8'h00);
      check_byte({7'h00, irq}, 8'h00);
      rx_send(f, 16'h003C, 8);
      dev_read(lfbl_pkg::STAT_OFS[f], rv);
      check_byte(rv, 8'h14);
      dev_write(lfbl_pkg::STAT_OFS[f], 8'h14);
      rx_send(f, 16'h0033, 8);
      dev_read(lfbl_pkg::STAT_OFS[f], rv);
      check_byte(rv, 8'h10);
      dev_write(lfbl_pkg::STAT_OFS[f], 8'h1C);
      sw_write(lfbl_pkg::H_STAT_OFS, 8'h03);
    end
    $display("Test receive done");
    // Destuffer: zero after exactly five ones dropped, after six kept
    dev_write(lfbl_pkg::CTRL_OFS[0], 8'h01);
    rx_send(0, 16'h019F, 9);
    dev_read(lfbl_pkg::RX_BYTE_OFS[0], rv);
    check_byte(rv, 8'hDF);
    rx_send(0, 16'h003F, 8);
    dev_read(lfbl_pkg::RX_BYTE_OFS[0], rv);
    check_byte(rv, 8'h3F);
    $display("Test destuff done");
    // Transmit: reset byte flushes first, then the new byte, then again
    dev_write(8'h7E, 8'hA5);
    tx_take(8, got);
    check_bits(got, 17'h00000);
    tx_take(16, got);
    check_bits(got, 17'h0A5A5);
    dev_read(lfbl_pkg::STAT_OFS[0], rv);
    check_byte(rv & 8'h08, 8'h08);
    // Stuffing: zero after five ones, not counted as data
    dev_write(lfbl_pkg::CTRL_OFS[0], 8'h11);
    dev_write(8'h7E, 8'hF8);
    tx_take(8, got);
    check_bits(got, 17'h000A5);
    tx_take(17, got);
    check_bits(got, 17'h1F0F8);
    $display("Test transmit done");
    // Slot ownership over every mix of source select, D4 and message controller
    for (int k = 0; k < 8; k++) begin
      dev_write(lfbl_pkg::CTRL_OFS[0], k[0] ? 8'h04 : 8'h00);
      @(posedge clk);
      d4_mode[0] <= k[1];
      msg_ctrl_tx[0] <= k[2];
      repeat (3) @(posedge clk);
      #1 check_byte({7'h00, tx_drive[0]}, {7'h00, ~(k[2] | (k[0] & k[1]))});
    end
    $display("Test ownership done");
    // D4 Fs insertion: the byte is taken only at multiframe boundaries
    @(posedge clk);
    msg_ctrl_tx[0] <= 1'b0;
    dev_write(lfbl_pkg::CTRL_OFS[0], 8'h20);
    dev_write(8'h7E, 8'h1C);
    mf_pulse();
    tx_take(16, got);
    check_bits(got, 17'h01C1C);
    dev_write(8'h7E, 8'h55);
    tx_take(8, got);
    check_bits(got, 17'h0001C);
    mf_pulse();
    tx_take(8, got);
    check_bits(got, 17'h00055);
    $display("Test multiframe load done");
    give_verdict();
  end
endmodule
